// [rtl/osmr_top.sv]
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
// Contract
// - output pin with replica enable drives divider
// - replica source chosen among six sysref dividers
// - replica taken after static digital delay
// - replica is continuous, never pulsed
// - mute enabled output silenced while source invalid
// - invalidity from per-pll selected unlock bits
// - mute disabled passes clock unsuppressed
// - outputs start together after lock
// - members leave reset on same cycle
// - membership needs all four enables set, three on ch0/1
// - sync from pin function 31 or software
// - asserted sync resets members, mutes low
// - release aligns group phases
// - non-members ignore sync
// - member post-divider invalidates all its outputs
// - non-member post-dividers keep running
// - divide-by-1 outputs never gated
// - pin polarity select; software bit level
module osmr_top
    import osmr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pll status, per pll
    input wire logic [OSMR_NPLL-1:0] analog_loss_of_lock,
    input wire logic [OSMR_NPLL-1:0] digital_loss_of_lock,
    input wire logic [OSMR_NPLL-1:0] phase_loss_of_lock,
    // general purpose pins
    input wire logic [OSMR_NPIN-1:0] pin_in,
    output logic [OSMR_NPIN-1:0] pin_out,
    output logic [OSMR_NPIN-1:0] pin_oe,
    // sysref dividers, signal after static digital delay
    input wire logic [OSMR_NSR-1:0] sysref_after_static_delay,
    // divider and driver control
    output logic [OSMR_NCH-1:0] divider_reset,
    output logic [OSMR_NCH-1:0] driver_mute,
    output logic [OSMR_NPLL-1:0] postdiv_reset
);
    typedef struct packed {
        logic [1:0] bus_ph;
        logic [7:0] bus_addr;
        logic [31:0] rdata;
        logic global_en;
        logic [OSMR_NPLL-1:0] pll_postdiv_align_enable;
        logic [OSMR_NCH-1:0] chan_sync_en;
        logic [OSMR_NCH-1:0] sysref_divider_align_enable;
        logic [OSMR_NCH-1:0] bypass;
        logic [OSMR_NCH-1:0] mute_en;
        logic [OSMR_NPLL-1:0] mute_on_analog_pll_unlock;
        logic [OSMR_NPLL-1:0] mute_on_digital_pll_unlock;
        logic [OSMR_NPLL-1:0] mute_on_digital_phase_unlock;
        logic [OSMR_NPIN-1:0] pin_output_enable;
        logic [OSMR_NPIN-1:0] pin_polarity_invert;
        logic [9:0] pin_function_select;
        logic [5:0] sysref_pin_replica_enable;
        logic [5:0] replica_src;
        logic [15:0] chan_mux;
        logic software_alignment_request;
        logic [OSMR_NPIN-1:0] s1;
        logic [OSMR_NPIN-1:0] s2;
        logic [OSMR_NPIN-1:0] s3;
        logic [OSMR_NPIN-1:0] pin_lvl;
        logic [OSMR_NSR-1:0] sr1;
        logic [OSMR_NSR-1:0] sr2;
        logic [OSMR_NSR-1:0] sr3;
        logic [OSMR_NSR-1:0] sr_stable;
        logic [OSMR_NPLL-1:0] lol1;
        logic [OSMR_NPLL-1:0] lol2;
        logic [OSMR_NPLL-1:0] lol3;
        logic [OSMR_NPLL-1:0] lol_lvl;
        logic [OSMR_NPLL-1:0] dl1;
        logic [OSMR_NPLL-1:0] dl2;
        logic [OSMR_NPLL-1:0] dl3;
        logic [OSMR_NPLL-1:0] dl_lvl;
        logic [OSMR_NPLL-1:0] pl1;
        logic [OSMR_NPLL-1:0] pl2;
        logic [OSMR_NPLL-1:0] pl3;
        logic [OSMR_NPLL-1:0] pl_lvl;
        logic sync_req;
        logic [OSMR_NCH-1:0] div_rst;
        logic [OSMR_NCH-1:0] mute;
        logic [OSMR_NPLL-1:0] pd_rst;
        logic [OSMR_NPIN-1:0] pout;
        logic [OSMR_NPIN-1:0] poe;
    } osmr_state_t;

    osmr_state_t st;
    osmr_state_t next_st;
    logic [OSMR_NPLL-1:0] pll_bad;
    logic [OSMR_NCH-1:0] member;
    logic [OSMR_NCH-1:0] src_bad;
    logic [1:0] sel;
    logic pin_sync;
    logic [OSMR_NSR-1:0] sr_lvl;
    // padded to four so the non-pll mux code indexes a real zero
    logic [3:0] bad_by_sel;
    logic [3:0] pd_rst_by_sel;
    logic [3:0] pd_en_by_sel;

    always_comb begin
        next_st = st;
        // bus: one wait-free data phase
        next_st.bus_ph = {hsel && hready && htrans == OSMR_HTRANS_NONSEQ && hwrite,
                          hsel && hready && htrans == OSMR_HTRANS_NONSEQ && !hwrite};
        if (hsel && hready) begin
            next_st.bus_addr = haddr[7:0];
        end
        if (st.bus_ph[1]) begin
            unique case (st.bus_addr)
                OSMR_A_CTRL: begin
                    next_st.global_en = hwdata[OSMR_B_GEN];
                    next_st.pll_postdiv_align_enable = hwdata[3:1];
                end
                OSMR_A_CHAN: begin
                    next_st.chan_sync_en = hwdata[7:0];
                    next_st.sysref_divider_align_enable = hwdata[15:8];
                    next_st.bypass = hwdata[23:16];
                    next_st.mute_en = hwdata[31:24];
                end
                OSMR_A_MUTE: begin
                    next_st.mute_on_analog_pll_unlock = hwdata[2:0];
                    next_st.mute_on_digital_pll_unlock = hwdata[6:4];
                    next_st.mute_on_digital_phase_unlock = hwdata[10:8];
                    next_st.chan_mux = hwdata[31:16];
                end
                OSMR_A_PIN: begin
                    next_st.pin_output_enable = hwdata[1:0];
                    next_st.pin_polarity_invert = hwdata[3:2];
                    next_st.pin_function_select = hwdata[13:4];
                end
                OSMR_A_SRC: begin
                    next_st.sysref_pin_replica_enable = hwdata[5:0];
                    next_st.replica_src = hwdata[13:8];
                end
                OSMR_A_SWREQ: begin
                    next_st.software_alignment_request = hwdata[OSMR_B_SWREQ];
                end
                default: begin
                end
            endcase
        end
        // pin and status synchronisers, three stages
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < OSMR_NPIN; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.pin_lvl[i] = st.s3[i];
            end
        end
        next_st.sr1 = sysref_after_static_delay;
        next_st.sr2 = st.sr1;
        next_st.sr3 = st.sr2;
        for (int s = 0; s < OSMR_NSR; s++) begin
            if (st.sr2[s] == st.sr3[s]) begin
                next_st.sr_stable[s] = st.sr3[s];
            end
        end
        // lock status comes from the pll domains, so it gets the same filter
        next_st.lol1 = analog_loss_of_lock;
        next_st.lol2 = st.lol1;
        next_st.lol3 = st.lol2;
        next_st.dl1 = digital_loss_of_lock;
        next_st.dl2 = st.dl1;
        next_st.dl3 = st.dl2;
        next_st.pl1 = phase_loss_of_lock;
        next_st.pl2 = st.pl1;
        next_st.pl3 = st.pl2;
        for (int p = 0; p < OSMR_NPLL; p++) begin
            if (st.lol2[p] == st.lol3[p]) begin
                next_st.lol_lvl[p] = st.lol3[p];
            end
            if (st.dl2[p] == st.dl3[p]) begin
                next_st.dl_lvl[p] = st.dl3[p];
            end
            if (st.pl2[p] == st.pl3[p]) begin
                next_st.pl_lvl[p] = st.pl3[p];
            end
        end
        // sync request
        pin_sync = 1'b0;
        for (int i = 0; i < OSMR_NPIN; i++) begin
            if (st.pin_function_select[i*5 +: 5] == OSMR_PIN_FUNC_SYNC && !st.pin_output_enable[i])
            begin
                pin_sync = pin_sync | (st.pin_lvl[i] ^ st.pin_polarity_invert[i]);
            end
        end
        next_st.sync_req = pin_sync | st.software_alignment_request;
        // source validity
        pll_bad = (st.lol_lvl & st.mute_on_analog_pll_unlock)
                | (st.dl_lvl & st.mute_on_digital_pll_unlock)
                | (st.pl_lvl & st.mute_on_digital_phase_unlock);
        for (int p = 0; p < OSMR_NPLL; p++) begin
            // only member post-dividers stop; others keep running
            next_st.pd_rst[p] = st.sync_req && st.global_en
                              && st.pll_postdiv_align_enable[p];
        end
        bad_by_sel = {1'b0, pll_bad};
        pd_rst_by_sel = {1'b0, st.pd_rst};
        pd_en_by_sel = {1'b0, st.pll_postdiv_align_enable};
        sel = 2'h0;
        member = '0;
        src_bad = '0;
        for (int c = 0; c < OSMR_NCH; c++) begin
            sel = st.chan_mux[c*2 +: 2];
            // mux code 3 is a non-pll source: never a member, never invalid
            member[c] = st.global_en && st.chan_sync_en[c]
                      && (st.sysref_divider_align_enable[c] || c < 2)
                      && sel != 2'h3 && pd_en_by_sel[sel];
            src_bad[c] = sel != 2'h3 && (bad_by_sel[sel] || pd_rst_by_sel[sel]);
            // every member drops on the same edge; bypassed ones are never gated
            next_st.div_rst[c] = st.sync_req && member[c] && !st.bypass[c];
            // release clears mute on one edge for members with mute_en off, one edge later for mute-enabled ones; lock recovery clears it per pll
            next_st.mute[c] = next_st.div_rst[c]
                            || (st.mute_en[c] && src_bad[c]);
        end
        // pin replica: a plain clock level, no pulser
        sr_lvl = st.sr_stable;
        for (int i = 0; i < OSMR_NPIN; i++) begin
            next_st.poe[i] = st.pin_output_enable[i];
            next_st.pout[i] = 1'b0;
            for (int s = 0; s < OSMR_NSR; s++) begin
                if (st.pin_output_enable[i] && st.sysref_pin_replica_enable[s]
                    && st.replica_src[s] == i[0]) begin
                    next_st.pout[i] = next_st.pout[i] | sr_lvl[s];
                end
            end
        end
        // read data
        next_st.rdata = 32'h0;
        if (next_st.bus_ph[0]) begin
            unique case (haddr[7:0])
                OSMR_A_CTRL: next_st.rdata = {28'h0, st.pll_postdiv_align_enable, st.global_en};
                OSMR_A_CHAN: next_st.rdata = {st.mute_en, st.bypass,
                                              st.sysref_divider_align_enable, st.chan_sync_en};
                OSMR_A_MUTE: next_st.rdata = {st.chan_mux, 5'h0, st.mute_on_digital_phase_unlock,
                                              1'b0, st.mute_on_digital_pll_unlock,
                                              1'b0, st.mute_on_analog_pll_unlock};
                OSMR_A_PIN: next_st.rdata = {18'h0, st.pin_function_select,
                                             st.pin_polarity_invert, st.pin_output_enable};
                OSMR_A_SRC: next_st.rdata = {18'h0, st.replica_src, 2'h0,
                                             st.sysref_pin_replica_enable};
                OSMR_A_STAT: next_st.rdata = {5'h0, st.pd_rst, st.mute, st.div_rst,
                                              7'h0, st.sync_req};
                OSMR_A_SWREQ: next_st.rdata = {25'h0, st.software_alignment_request, 6'h0};
                default: next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign divider_reset = st.div_rst;
    assign driver_mute = st.mute;
    assign postdiv_reset = st.pd_rst;
    assign pin_out = st.pout;
    assign pin_oe = st.poe;

    a_member_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.sync_req && member[1] && !st.bypass[1]) |=> divider_reset[1] && driver_mute[1])
        else $error("member divider not reset");
    a_nonmember_free: assert property (@(posedge hclk) disable iff (!hresetn)
        !member[1] |=> !divider_reset[1])
        else $error("non-member divider reset");
    a_bypass_free: assert property (@(posedge hclk) disable iff (!hresetn)
        st.bypass[0] |=> !divider_reset[0])
        else $error("bypassed divider gated");
    a_mute_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.mute_en[3] && !next_st.div_rst[3]) |=> !driver_mute[3])
        else $error("unmuted output silenced");
    a_mute_bad: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mute_en[4] && src_bad[4]) |=> driver_mute[4])
        else $error("invalid source not muted");
    a_sw_sync: assert property (@(posedge hclk) disable iff (!hresetn)
        st.software_alignment_request |=> st.sync_req)
        else $error("software request lost");
    a_pd_run: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.pll_postdiv_align_enable[0] |=> !postdiv_reset[0])
        else $error("non-member post-divider stopped");
    a_group_release: assert property (@(posedge hclk) disable iff (!hresetn)
        (member[1] && member[2] && !st.bypass[1] && !st.bypass[2])
        |=> divider_reset[1] == divider_reset[2])
        else $error("group members split");
    a_pin_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.pin_output_enable[0] |=> !pin_out[0] && !pin_oe[0])
        else $error("pin driven while input");

    // post-divider and release behaviour
    a_pd_member: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.sync_req && st.global_en && st.pll_postdiv_align_enable[0]) |=> postdiv_reset[0])
        else $error("member post-divider not reset");
    a_pd_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.sync_req |=> postdiv_reset == '0)
        else $error("post-divider reset without sync");
    a_pd_invalid: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mute_en[4] && st.chan_mux[9:8] == 2'h0 && st.pd_rst[0]) |=> driver_mute[4])
        else $error("output of reset post-divider not muted");
    a_all_release: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.sync_req |=> divider_reset == '0)
        else $error("divider held after release");
    a_no_global: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.global_en |=> divider_reset == '0 && postdiv_reset == '0)
        else $error("sync acted with global enable off");
    a_need_postdiv: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.chan_mux[3:2] == 2'h0 && !st.pll_postdiv_align_enable[0]) |=> !divider_reset[1])
        else $error("member without post-divider enable");

    // sync request path
    a_pin_sync: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.pin_function_select[4:0] == OSMR_PIN_FUNC_SYNC && !st.pin_output_enable[0]
         && st.pin_lvl[0] != st.pin_polarity_invert[0]) |=> st.sync_req)
        else $error("pin sync request lost");
    a_sync_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.software_alignment_request && !pin_sync) |=> !st.sync_req)
        else $error("sync request without source");
    a_func_other: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.pin_function_select[4:0] != OSMR_PIN_FUNC_SYNC && !st.software_alignment_request
         && st.pin_function_select[9:5] != OSMR_PIN_FUNC_SYNC) |=> !st.sync_req)
        else $error("sync taken from a pin of another function");

    // auto-mute
    a_unlock_bad: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mute_on_analog_pll_unlock[0] && st.lol_lvl[0]) |-> pll_bad[0])
        else $error("selected unlock not seen");
    a_unlock_masked: assert property (@(posedge hclk) disable iff (!hresetn)
        (!st.mute_on_analog_pll_unlock[0] && !st.mute_on_digital_pll_unlock[0]
         && !st.mute_on_digital_phase_unlock[0]) |-> !pll_bad[0])
        else $error("unselected unlock made source invalid");
    a_mux_other: assert property (@(posedge hclk) disable iff (!hresetn)
        st.chan_mux[9:8] == 2'h3 |-> !src_bad[4])
        else $error("non-pll source judged invalid");
    a_start_together: assert property (@(posedge hclk) disable iff (!hresetn)
        (!src_bad[4] && !next_st.div_rst[4]) |=> !driver_mute[4])
        else $error("output held muted after lock");

    // pin replica
    a_replica_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.pin_output_enable[1] && st.sysref_pin_replica_enable[2] && st.replica_src[2]
         && st.sr_stable[2]) |=> pin_out[1])
        else $error("replica not driven");
    a_replica_none: assert property (@(posedge hclk) disable iff (!hresetn)
        st.sysref_pin_replica_enable == '0 |=> pin_out == '0)
        else $error("pin driven with no replica source");
    a_replica_oe: assert property (@(posedge hclk) disable iff (!hresetn)
        st.pin_output_enable[1] |=> pin_oe[1])
        else $error("output pin not enabled");
    a_replica_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.pin_output_enable[1] && st.sysref_pin_replica_enable == 6'h04 && st.replica_src[2])
        |=> pin_out[1] == $past(st.sr_stable[2]))
        else $error("replica does not follow divider level");

    // register bus
    a_read_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !(hsel && hready && htrans == OSMR_HTRANS_NONSEQ && !hwrite) |=> hrdata == '0)
        else $error("read data outside a read");
endmodule

// [rtl/osmr_pkg.sv]
package osmr_pkg;
    // channel groups that carry a sysref divider: 2/3, 4/5, 6/7
    localparam int OSMR_NCH = 8;
    localparam int OSMR_NSR = 6;
    localparam int OSMR_NPLL = 3;
    localparam int OSMR_NPIN = 2;
    localparam logic [4:0] OSMR_PIN_FUNC_SYNC = 5'h1f;
    // register map (byte addresses)
    localparam logic [7:0] OSMR_A_CTRL = 8'h00;
    localparam logic [7:0] OSMR_A_CHAN = 8'h04;
    localparam logic [7:0] OSMR_A_MUTE = 8'h08;
    localparam logic [7:0] OSMR_A_PIN = 8'h0c;
    localparam logic [7:0] OSMR_A_SRC = 8'h10;
    localparam logic [7:0] OSMR_A_STAT = 8'h14;
    // the software request register is known by index; its byte address is four times that
    localparam int OSMR_I_SWREQ = 21;
    localparam logic [7:0] OSMR_A_SWREQ = 8'(OSMR_I_SWREQ * 4);
    // field positions
    localparam int OSMR_B_SWREQ = 6;
    localparam int OSMR_B_GEN = 0;
    localparam int OSMR_B_PDEN = 1;
    localparam logic [31:0] OSMR_RST = 32'h0000_0000;
    localparam logic [1:0] OSMR_HTRANS_NONSEQ = 2'h2;
endpackage

// [test/osmr_far_model.sv]
`timescale 1ns/1ns
module osmr_far_model
    import osmr_pkg::*;
(
    // clock
    input wire logic hclk,
    // bench settings: sysref levels, {phase, digital, analog} unlock, pin levels
    input wire logic [OSMR_NSR-1:0] sr_set,
    input wire logic [3*OSMR_NPLL-1:0] lol_set,
    input wire logic [OSMR_NPIN-1:0] pin_set,
    // device side
    input wire logic [OSMR_NPIN-1:0] pin_out,
    input wire logic [OSMR_NPIN-1:0] pin_oe,
    output logic [OSMR_NPIN-1:0] pin_in,
    output logic [OSMR_NSR-1:0] sysref_after_static_delay,
    output logic [OSMR_NPLL-1:0] analog_loss_of_lock,
    output logic [OSMR_NPLL-1:0] digital_loss_of_lock,
    output logic [OSMR_NPLL-1:0] phase_loss_of_lock
);
    initial begin
        sysref_after_static_delay = '0;
        {phase_loss_of_lock, digital_loss_of_lock, analog_loss_of_lock} = '0;
    end
    // status changes just after an edge, like the real pll monitors
    always @(posedge hclk) begin
        sysref_after_static_delay <= sr_set;
        {phase_loss_of_lock, digital_loss_of_lock, analog_loss_of_lock} <= lol_set;
    end
    // a driven pin shows the device's level, otherwise the board's
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_set);
endmodule

// [test/tb_output_sync_mute_replication.sv]
`timescale 1ns/1ns
module tb_output_sync_mute_replication;
    import osmr_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0] htrans = '0, pin_out, pin_oe, pin_in, pin_set = '0;
    logic [2:0] hsize = 3'h2, alol, dlol, plol, postdiv_reset;
    logic [7:0] divider_reset, driver_mute;
    logic [5:0] sr_set = '0, sysref;
    logic [8:0] lol_set = '0;
    logic hreadyout, hresp;
    wire hready = hreadyout;
    int mismatches = 0, n_compared = 0;
    initial begin
        forever #25 hclk = ~hclk;
    end
    osmr_top i_osmr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analog_loss_of_lock(alol),
        .digital_loss_of_lock(dlol), .phase_loss_of_lock(plol), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .sysref_after_static_delay(sysref),
        .divider_reset(divider_reset), .driver_mute(driver_mute),
        .postdiv_reset(postdiv_reset));
    osmr_far_model i_osmr_far_model (.hclk(hclk), .sr_set(sr_set), .lol_set(lol_set),
        .pin_set(pin_set), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .sysref_after_static_delay(sysref), .analog_loss_of_lock(alol),
        .digital_loss_of_lock(dlol), .phase_loss_of_lock(plol));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one single word transfer; the master never assumes the slave's latency
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= OSMR_HTRANS_NONSEQ;
        hwrite <= wr;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        q = hrdata;
        chk("hresp", 0, {31'h0, hresp});
        if (n >= 100) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        cyc(10);
        hresetn <= 1'b1;
        cyc(1);
        chk("idle outputs", 0, {pin_oe, divider_reset, driver_mute, postdiv_reset});
        bus(1, 8'h20, 32'hffff_ffff);
        bus(0, 8'h20, 0);
        chk("unmapped read", 0, q);
        // members: ch0..3, ch0 bypassed; ch4 mute-enabled non-member on pll0
        bus(1, OSMR_A_CHAN, 32'h1001_ff0f);
        bus(1, OSMR_A_CTRL, 32'h0000_0001);
        bus(1, OSMR_A_SWREQ, 32'h40);
        cyc(6);
        chk("no postdiv enable", 0, divider_reset);
        bus(1, OSMR_A_SWREQ, 0);
        bus(1, OSMR_A_CTRL, 32'h0000_0003);
        bus(0, OSMR_A_CTRL, 0);
        chk("ctrl readback", 32'h3, q);
        bus(1, OSMR_A_SWREQ, 32'h40);
        cyc(6);
        chk("sw sync reset", 8'h0e, divider_reset);
        chk("sw sync mute", 8'h1e, driver_mute);
        chk("postdiv reset", 3'h1, postdiv_reset);
        bus(1, OSMR_A_SWREQ, 0);
        // the group must let go on one cycle, never partly
        repeat (8) begin
            cyc(1);
            chk("common release", 1, divider_reset === 8'h0e || divider_reset === 8'h0);
        end
        chk("released", 0, {divider_reset, postdiv_reset});
        for (int p = 0; p < 2; p++) begin
            pin_set <= 2'(p);
            bus(1, OSMR_A_PIN, 32'h1f0 | (p << 2));
            cyc(8);
            chk("pin idle", 0, divider_reset);
            pin_set <= 2'(1 - p);
            cyc(8);
            chk("pin sync", 8'h0e, divider_reset);
            pin_set <= 2'(p);
            cyc(8);
            chk("pin release", 0, divider_reset);
        end
        // auto-mute: ch4 muted on the selected unlock kind, ch5 has mute off
        bus(1, OSMR_A_CHAN, 32'h1000_0000);
        for (int k = 0; k < 3; k++) begin
            bus(1, OSMR_A_MUTE, 32'h1 << (4 * k));
            lol_set <= 9'h1 << (3 * k);
            cyc(8);
            chk("mute on unlock", 8'h10, driver_mute);
            lol_set <= 9'h1 << (3 * ((k + 1) % 3));
            cyc(8);
            chk("other kind ignored", 0, driver_mute);
        end
        // analog unlock of pll0 is selected and present, but ch4 now takes a non-pll source
        bus(1, OSMR_A_MUTE, 32'h0300_0001);
        cyc(8);
        chk("non-pll source", 0, driver_mute);
        lol_set <= '0;
        // replica of sysref divider 2 on pin 1
        bus(1, OSMR_A_PIN, 32'h2);
        bus(1, OSMR_A_SRC, 32'h404);
        sr_set <= 6'h04;
        cyc(8);
        chk("replica high", 32'h5, {pin_oe, pin_out[1]});
        sr_set <= 6'h3b;
        cyc(8);
        chk("replica low", 0, pin_out[1]);
        report_and_stop();
    end
endmodule
